// *** tpu_pkg.sv ***
// constants, register map and control layout of the timer pin unit
package tpu_pkg;
  localparam int          TPU_TIMERS   = 3;
  localparam int          TPU_PINS     = 2;
  localparam int          TPU_SLOTS    = 4;
  localparam int          TPU_AW       = 8;
  localparam logic [1:0]  TPU_PRESCALE_SRC = 2'h2;
  // word index inside one timer's block; block stride is 16 bytes
  localparam logic [1:0]  TPU_REG_COUNT = 2'h0;
  localparam logic [1:0]  TPU_REG_MAXA  = 2'h1;
  localparam logic [1:0]  TPU_REG_MAXB  = 2'h2;
  localparam logic [1:0]  TPU_REG_CTRL  = 2'h3;
  localparam logic [7:0]  TPU_BLOCK_STRIDE = 8'h10;
  localparam logic [15:0] TPU_COUNT_RST = 16'h0000;
  localparam logic [15:0] TPU_MAX_RST   = 16'h0000;
  localparam logic [6:0]  TPU_CTRL_WMASK_T2 = 7'h07;

  typedef struct packed {
    logic activeMaxRegisterFlag;
    logic retriggerSelect;
    logic prescale;
    logic external;
    logic alternate;
    logic continuous;
    logic enable;
  } tpu_ctrl_type;

  localparam tpu_ctrl_type TPU_CTRL_RST = '0;
endpackage

// *** tpu_sync.sv ***
// two-stage pin synchronizer with rising-edge detect
`timescale 1ns/1ps
module tpu_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  // only a full low-to-high change counts as one event
  assign rise  = sync_q & ~prev_q;
endmodule

// *** tpu_pin_timer.sv ***
// three-timer unit with time-multiplexed counter element, pins and APB slave
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module tpu_pin_timer
  import tpu_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [TPU_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [TPU_PINS-1:0] timerIn,
  output logic      [TPU_PINS-1:0] timerOut
);
  logic [1:0]           slot_q;
  logic [15:0]          cnt_q   [TPU_TIMERS];
  logic [15:0]          maxA_q  [TPU_TIMERS];
  logic [15:0]          maxB_q  [TPU_TIMERS];
  tpu_ctrl_type         ctrl_q  [TPU_TIMERS];
  logic [15:0]          cntNext [TPU_TIMERS];
  logic [TPU_TIMERS-1:0] svc, inc, restart, wrap, riuNext;
  logic [TPU_PINS-1:0]  pinLevel, pinRise, edgeFlag_q, t2Pend_q, out_q;
  logic [31:0]          prdata_q;
  logic                 waited_q;
  logic                 access, regHit, wrEn;
  logic [1:0]           regIdx, regSel;
  logic [TPU_TIMERS-1:0] edgeAll, gateAll, t2All;

  tpu_sync #(.W(TPU_PINS)) u_tpu_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (timerIn),
    .level   (pinLevel),
    .rise    (pinRise)
  );

  // timer 2 has no pin: its slots see no edge, an open gate and no prescale pulse
  assign edgeAll = {{(TPU_TIMERS-TPU_PINS){1'b0}}, edgeFlag_q};
  assign gateAll = {{(TPU_TIMERS-TPU_PINS){1'b1}}, pinLevel};
  assign t2All   = {{(TPU_TIMERS-TPU_PINS){1'b0}}, t2Pend_q};

  function automatic logic [15:0] activeMax(input tpu_ctrl_type c, input logic [15:0] a,
                                            input logic [15:0] b);
    return (c.alternate && c.activeMaxRegisterFlag) ? b : a;
  endfunction

  // slot walk: a timer sees the counter element once per four clocks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slot_q <= 2'h0;
    end else begin
      slot_q <= slot_q + 2'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < TPU_TIMERS; i++) begin
      logic       edgeSeen;
      logic       gate;
      logic       evt;
      logic [15:0] sum;
      edgeSeen   = edgeAll[i];
      gate       = gateAll[i];
      evt        = 1'b1;
      sum        = cnt_q[i] + 16'h0001;
      svc[i]     = (slot_q == i[1:0]);
      // prescaled timers count timer 2 wraps
      if (ctrl_q[i].prescale) begin
        evt = t2All[i];
      end
      // retrigger edge restarts the cycle from zero
      restart[i] = svc[i] && ctrl_q[i].enable && !ctrl_q[i].external
                   && ctrl_q[i].retriggerSelect && edgeSeen;
      if (ctrl_q[i].external) begin
        inc[i] = svc[i] && ctrl_q[i].enable && edgeSeen;
      end else begin
        inc[i] = svc[i] && ctrl_q[i].enable && evt && (ctrl_q[i].retriggerSelect || gate);
      end
      inc[i]     = inc[i] && !restart[i];
      wrap[i]    = inc[i] && (sum == activeMax(ctrl_q[i], maxA_q[i], maxB_q[i]));
      cntNext[i] = restart[i] ? 16'h0000 : (wrap[i] ? 16'h0000 : (inc[i] ? sum : cnt_q[i]));
      // flag flips only on wraps in dual mode
      riuNext[i] = ctrl_q[i].alternate
                   && (ctrl_q[i].activeMaxRegisterFlag ^ wrap[i]);
    end
  end

  // pin edges latched until their timer's slot consumes them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edgeFlag_q <= '0;
    end else begin
      for (int i = 0; i < TPU_PINS; i++) begin
        if (pinRise[i]) begin
          edgeFlag_q[i] <= 1'b1;
        end else if (svc[i]) begin
          edgeFlag_q[i] <= 1'b0;
        end
      end
    end
  end

  // timer 2 wraps held per timer until that timer is serviced
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      t2Pend_q <= '0;
    end else begin
      for (int i = 0; i < TPU_PINS; i++) begin
        if (wrap[TPU_PRESCALE_SRC]) begin
          t2Pend_q[i] <= 1'b1;
        end else if (svc[i]) begin
          t2Pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // APB decode: one wait state, data registered before pready rises
  assign regIdx = paddr[5:4];
  assign regSel = paddr[3:2];
  assign regHit = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) && (regIdx != 2'h3);
  assign access = psel && penable;
  assign pready = access && waited_q;
  assign pslverr = pready && !regHit;
  assign wrEn   = pready && pwrite && regHit;
  assign prdata = prdata_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waited_q <= 1'b0;
    end else begin
      waited_q <= access && !waited_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h00000000;
    end else if (access && !waited_q) begin
      prdata_q <= 32'h00000000;
      if (regHit && !pwrite) begin
        unique case (regSel)
          TPU_REG_COUNT: prdata_q <= {16'h0000, cnt_q[regIdx]};
          TPU_REG_MAXA:  prdata_q <= {16'h0000, maxA_q[regIdx]};
          TPU_REG_MAXB:  prdata_q <= {16'h0000, maxB_q[regIdx]};
          TPU_REG_CTRL: begin
            prdata_q <= {24'h000000,
                         (regIdx < 2'h2) ? out_q[regIdx[0]] : 1'b1, ctrl_q[regIdx]};
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TPU_TIMERS; i++) begin
        maxA_q[i] <= TPU_MAX_RST;
        maxB_q[i] <= TPU_MAX_RST;
      end
    end else if (wrEn && regSel == TPU_REG_MAXA) begin
      maxA_q[regIdx] <= pwdata[15:0];
    end else if (wrEn && regSel == TPU_REG_MAXB) begin
      maxB_q[regIdx] <= pwdata[15:0];
    end
  end

  // a software write to the count wins over the counter element
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TPU_TIMERS; i++) begin
        cnt_q[i] <= TPU_COUNT_RST;
      end
    end else begin
      for (int i = 0; i < TPU_TIMERS; i++) begin
        if (wrEn && regSel == TPU_REG_COUNT && regIdx == i[1:0]) begin
          cnt_q[i] <= pwdata[15:0];
        end else begin
          cnt_q[i] <= cntNext[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TPU_TIMERS; i++) begin
        ctrl_q[i] <= TPU_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < TPU_TIMERS; i++) begin
        ctrl_q[i].activeMaxRegisterFlag <= riuNext[i];
        // non-continuous timers stop at cycle end
        if (wrap[i] && !ctrl_q[i].continuous
            && (ctrl_q[i].activeMaxRegisterFlag || !ctrl_q[i].alternate)) begin
          ctrl_q[i].enable <= 1'b0;
        end
        // software setting the enable wins over the automatic clear
        if (wrEn && regSel == TPU_REG_CTRL && regIdx == i[1:0]) begin
          ctrl_q[i].enable     <= pwdata[0];
          ctrl_q[i].continuous <= pwdata[1];
          ctrl_q[i].alternate  <= pwdata[2];
          if (i < TPU_PINS) begin
            ctrl_q[i].external        <= pwdata[3];
            ctrl_q[i].prescale        <= pwdata[4];
            ctrl_q[i].retriggerSelect <= pwdata[5];
          end
        end
      end
    end
  end

  // output from the wrap in single mode and from the next flag value in dual mode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '1;
    end else begin
      for (int i = 0; i < TPU_PINS; i++) begin
        out_q[i] <= ctrl_q[i].alternate ? !riuNext[i] : !wrap[i];
      end
    end
  end

  assign timerOut = out_q;

  logic [15:0] cnt0;
  tpu_ctrl_type c0;
  logic [15:0] cnt1;
  tpu_ctrl_type c1;
  assign cnt0 = cnt_q[0];
  assign c0   = ctrl_q[0];
  assign cnt1 = cnt_q[1];
  assign c1   = ctrl_q[1];

  chk_slot_rate: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (cnt0 != $past(cnt0)) && !$past(wrEn) |-> $past(slot_q) == 2'h0)
    else $error("timer 0 count moved outside its slot");

  chk_edge_consumed: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    svc[0] && !pinRise[0] |=> !edgeFlag_q[0])
    else $error("edge flag survived its service slot");

  chk_pulse_width: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wrap[0] && !c0.alternate |=> !timerOut[0] ##1 timerOut[0])
    else $error("single mode pulse not one clock low");

  chk_dual_level: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    c0.alternate && $past(c0.alternate) |-> timerOut[0] == !c0.activeMaxRegisterFlag)
    else $error("dual mode level does not follow register in use");

  chk_oneshot_stop: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wrap[0] && !c0.alternate && !c0.continuous && !wrEn |=> !c0.enable)
    else $error("one-shot did not stop at cycle end");

  chk_gate_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    svc[1] && c1.enable && !c1.external && !c1.retriggerSelect && !pinLevel[1] && !wrEn
    |=> cnt1 == $past(cnt1))
    else $error("gated timer counted with pin low");

  chk_retrig_zero: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    restart[0] && !wrEn |=> cnt0 == 16'h0000)
    else $error("retrigger edge did not clear count");

  chk_riu_keep: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    restart[0] && c0.alternate && !wrEn |=> $stable(c0.activeMaxRegisterFlag))
    else $error("retrigger edge changed register-in-use flag");

  chk_ext_count: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    svc[0] && c0.external && c0.enable && edgeFlag_q[0] && !wrEn
    |=> cnt0 != $past(cnt0) || cnt0 == 16'h0000)
    else $error("latched external edge not counted");

  chk_idle_high: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !c0.alternate && !c0.enable ##1 !c0.alternate |-> timerOut[0])
    else $error("single mode output not idle high");

  chk_cont_keep: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wrap[0] && c0.continuous && !wrEn |=> c0.enable)
    else $error("continuous timer dropped its enable at cycle end");

  chk_pulse_t1: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wrap[1] && !c1.alternate |=> !timerOut[1] ##1 timerOut[1])
    else $error("timer 1 single mode pulse not one clock low");

  chk_level_t1: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    c1.alternate && $past(c1.alternate) |-> timerOut[1] == !c1.activeMaxRegisterFlag)
    else $error("timer 1 dual mode level does not follow register in use");
endmodule

// *** tpu_pin_source.sv ***
// event source model driving the two timer input pins
`timescale 1ns/1ps
module tpu_pin_source
  import tpu_pkg::*;
(
  input  wire logic                ref_clk,
  output logic      [TPU_PINS-1:0] timerIn
);
  initial timerIn = '0;

  task automatic setLevel(input int idx, input logic v);
    @(posedge ref_clk);
    timerIn[idx] <= v;
  endtask

  task automatic pulse(input int idx);
    setLevel(idx, 1'b0);
    repeat (4) @(posedge ref_clk);
    setLevel(idx, 1'b1);
  endtask
endmodule

// *** timer_pin_modes_test.sv ***
// self-checking bench for the timer pin unit over APB
`timescale 1ns/1ps
module timer_pin_modes_test
  import tpu_pkg::*;
;
  logic                ref_clk;
  logic                nrst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [TPU_AW-1:0]   paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [TPU_PINS-1:0] timerIn;
  logic [TPU_PINS-1:0] timerOut;
  logic [31:0]         rdVal;
  logic                rdErr;
  int                  errTotal = 0;
  int                  comparisons = 0;
  int                  cycles = 0;

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  tpu_pin_timer u_tpu_pin_timer (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .timerIn  (timerIn),
    .timerOut (timerOut)
  );

  tpu_pin_source u_tpu_pin_source (
    .ref_clk (ref_clk),
    .timerIn (timerIn)
  );

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hung handshake ends here
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errTotal++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // read-to-read spacing is k+4 clocks, a multiple of the service period
  task automatic rate(input logic [7:0] a, input int k, input int exp);
    logic [31:0] v0;
    rd(a);
    v0 = rdVal;
    repeat (k) @(posedge ref_clk);
    rd(a);
    cmp((rdVal - v0) & 32'hFFFF, exp);
  endtask

  task automatic lows(input int i, input int n, input int expL, input int expF);
    int   l;
    int   f;
    logic p;
    l = 0;
    f = 0;
    @(negedge ref_clk);
    p = timerOut[i];
    repeat (n) begin
      @(negedge ref_clk);
      if (timerOut[i] === 1'b0) l++;
      if (timerOut[i] === 1'b0 && p === 1'b1) f++;
      p = timerOut[i];
    end
    cmp(l, expL);
    cmp(f, expF);
  endtask

  task automatic edgeOn(input int i);
    u_tpu_pin_source.pulse(i);
    repeat (8) @(posedge ref_clk);
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h0C);
    cmp(rdVal, 32'h80);
    rd(8'h30);
    cmp({rdVal[30:0], rdErr}, 32'h1);
    $display("test reset done");
    wr(8'h04, 32'h100);
    wr(8'h0C, 32'h09);
    repeat (5) edgeOn(0);
    rd(8'h00);
    cmp(rdVal, 32'h5);
    wr(8'h0C, 32'h08);
    edgeOn(0);
    wr(8'h0C, 32'h09);
    rd(8'h00);
    cmp(rdVal, 32'h5);
    $display("test external done");
    wr(8'h14, 32'h1000);
    wr(8'h1C, 32'h01);
    rate(8'h10, 36, 0);
    u_tpu_pin_source.setLevel(1, 1'b1);
    rate(8'h10, 36, 10);
    wr(8'h1C, 32'h00);
    rate(8'h10, 36, 0);
    $display("test gated done");
    wr(8'h24, 32'h4);
    wr(8'h2C, 32'h03);
    wr(8'h04, 32'h1000);
    wr(8'h0C, 32'h11);
    rate(8'h00, 76, 5);
    $display("test prescale done");
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h3);
    wr(8'h1C, 32'h03);
    lows(1, 120, 10, 10);
    wr(8'h1C, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h4);
    wr(8'h14, 32'h2);
    wr(8'h1C, 32'h07);
    lows(1, 120, 80, 5);
    wr(8'h1C, 32'h0);
    lows(1, 20, 0, 0);
    $display("test output done");
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h0C, 32'h21);
    u_tpu_pin_source.pulse(0);
    repeat (10) @(posedge ref_clk);
    u_tpu_pin_source.pulse(0);
    lows(0, 14, 0, 0);
    lows(0, 46, 1, 1);
    rd(8'h0C);
    cmp(rdVal, 32'hA0);
    rd(8'h00);
    cmp(rdVal, 32'h0);
    edgeOn(0);
    rd(8'h00);
    cmp(rdVal, 32'h0);
    $display("test one-shot done");
    wr(8'h0C, 32'h23);
    u_tpu_pin_source.pulse(0);
    repeat (10) @(posedge ref_clk);
    lows(0, 80, 4, 4);
    rd(8'h0C);
    cmp({31'h0, rdVal[0]}, 32'h1);
    $display("test continuous done");
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h20);
    wr(8'h04, 32'h2);
    wr(8'h0C, 32'h27);
    edgeOn(0);
    rd(8'h0C);
    cmp(rdVal, 32'h67);
    $display("test retrigger flag done");
    wr(8'h0C, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2);
    wr(8'h0C, 32'h09);
    edgeOn(0);
    u_tpu_pin_source.pulse(0);
    lows(0, 20, 1, 1);
    rd(8'h0C);
    cmp(rdVal, 32'h88);
    $display("test external output done");
    finish_test();
  end
endmodule
